// >>> logic/power_current_ratio_limits.sv
// Summary of operation
// RULE_01: Power ceiling in bits 14:0, eighth watts
// RULE_02: Bit 15 enables power ceiling override
// RULE_03: Current ceiling in bits 30:16, eighth amps
// RULE_04: Bit 31 enables current ceiling override
// RULE_05: Ratio register writable only when capability bit set
// RULE_06: Bits 7:0 ratio for one core
// RULE_07: Bits 15:8 ratio for two cores
// RULE_08: Bits 23:16 ratio for three cores
// RULE_09: Bits 31:24 ratio for four cores
// RULE_10: Upper 32 bits read zero, writes discarded
// RULE_11: Locked ratio register ignores writes entirely
`timescale 1ns/10ps
`default_nettype none
module power_current_ratio_limits (
    input wire logic clk,
    input wire logic rst,
    input wire logic [caps_pkg::ADDR_W-1:0] addr,
    input wire logic [caps_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [caps_pkg::DATA_W-1:0] platform_capability_word,
    output wire logic [caps_pkg::DATA_W-1:0] rdata,
    output wire logic [caps_pkg::LIMIT_W-1:0] thermal_design_power_ceiling,
    output wire logic power_override_en,
    output wire logic [caps_pkg::LIMIT_W-1:0] design_current_ceiling,
    output wire logic current_override_en,
    output wire logic [caps_pkg::RATIO_W-1:0] one_core_ratio,
    output wire logic [caps_pkg::RATIO_W-1:0] two_core_ratio,
    output wire logic [caps_pkg::RATIO_W-1:0] three_core_ratio,
    output wire logic [caps_pkg::RATIO_W-1:0] four_core_ratio
);
    import caps_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    caps_if u_if();

    pwr_caps_reg u_pwr (
        .clk(clk),
        .rst(rst),
        .bus(u_if)
    );

    ratio_caps_reg u_ratio (
        .clk(clk),
        .rst(rst),
        .bus(u_if)
    );

    // Reserved upper word never reaches storage
    assign u_if.wdata = wdata[LIVE_W-1:0]; // RULE_10
    assign u_if.pwr_we = wr && addr_hits(addr, PWR_ADDR);
    assign u_if.ratio_we = wr && addr_hits(addr, RATIO_ADDR);
    // Sampled live on each write; no latching of the capability bit
    assign u_if.ratio_writable = platform_capability_word[WRITABLE_BIT]; // RULE_05

    // Read data live one cycle only, zero otherwise
    always_comb begin
        state_next = state_reg;
        state_next.rdata = RDATA_RESET;
        if (rd) begin
            if (addr_hits(addr, PWR_ADDR)) begin
                state_next.rdata = widen(u_if.pwr_q); // RULE_10
            end else if (addr_hits(addr, RATIO_ADDR)) begin
                state_next.rdata = widen(u_if.ratio_q); // RULE_10
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{rdata: RDATA_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign thermal_design_power_ceiling = u_if.pwr_q.pwr_limit; // RULE_01
    assign power_override_en = u_if.pwr_q.pwr_ovr; // RULE_02
    assign design_current_ceiling = u_if.pwr_q.cur_limit; // RULE_03
    assign current_override_en = u_if.pwr_q.cur_ovr; // RULE_04
    assign one_core_ratio = u_if.ratio_q.one; // RULE_06
    assign two_core_ratio = u_if.ratio_q.two; // RULE_07
    assign three_core_ratio = u_if.ratio_q.three; // RULE_08
    assign four_core_ratio = u_if.ratio_q.four; // RULE_09

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_pwr_write;
        wr && addr_hits(addr, PWR_ADDR);
    endsequence

    sequence s_ratio_open_write;
        wr && addr_hits(addr, RATIO_ADDR)
            && platform_capability_word[WRITABLE_BIT];
    endsequence

    sequence s_ratio_locked_write;
        wr && addr_hits(addr, RATIO_ADDR)
            && !platform_capability_word[WRITABLE_BIT];
    endsequence

    // Read strobes, decoded the same way as the read path
    sequence s_pwr_read;
        rd && addr_hits(addr, PWR_ADDR);
    endsequence

    sequence s_ratio_read;
        rd && addr_hits(addr, RATIO_ADDR);
    endsequence

    property p_pwr_limit;
        s_pwr_write |=> thermal_design_power_ceiling
            == $past(wdata[PWR_LIMIT_MSB:PWR_LIMIT_LSB]);
    endproperty
    a_pwr_limit: assert property (p_pwr_limit) // RULE_01
        else $error("power ceiling not stored");

    property p_pwr_ovr;
        s_pwr_write |=> power_override_en == $past(wdata[PWR_OVR_BIT]);
    endproperty
    a_pwr_ovr: assert property (p_pwr_ovr) // RULE_02
        else $error("power override not stored");

    property p_cur_limit;
        s_pwr_write |=> design_current_ceiling
            == $past(wdata[CUR_LIMIT_MSB:CUR_LIMIT_LSB]);
    endproperty
    a_cur_limit: assert property (p_cur_limit) // RULE_03
        else $error("current ceiling not stored");

    property p_cur_ovr;
        s_pwr_write |=> current_override_en == $past(wdata[CUR_OVR_BIT]);
    endproperty
    a_cur_ovr: assert property (p_cur_ovr) // RULE_04
        else $error("current override not stored");

    property p_pwr_readback;
        rd && addr_hits(addr, PWR_ADDR) |=>
            rdata[LIVE_W-1:0] == {$past(current_override_en),
                                  $past(design_current_ceiling),
                                  $past(power_override_en),
                                  $past(thermal_design_power_ceiling)};
    endproperty
    a_pwr_readback: assert property (p_pwr_readback) // RULE_01
        else $error("power register readback wrong");

    property p_ratio_open;
        s_ratio_open_write |=> {four_core_ratio, three_core_ratio,
                                two_core_ratio, one_core_ratio}
            == $past(wdata[LIVE_W-1:0]);
    endproperty
    a_ratio_open: assert property (p_ratio_open) // RULE_05
        else $error("unlocked ratio write lost");

    property p_one_core;
        s_ratio_open_write |=> one_core_ratio
            == $past(wdata[ONE_CORE_LSB+RATIO_W-1:ONE_CORE_LSB]);
    endproperty
    a_one_core: assert property (p_one_core) // RULE_06
        else $error("one-core ratio wrong");

    property p_two_core;
        s_ratio_open_write |=> two_core_ratio
            == $past(wdata[TWO_CORE_LSB+RATIO_W-1:TWO_CORE_LSB]);
    endproperty
    a_two_core: assert property (p_two_core) // RULE_07
        else $error("two-core ratio wrong");

    property p_three_core;
        s_ratio_open_write |=> three_core_ratio
            == $past(wdata[THREE_CORE_LSB+RATIO_W-1:THREE_CORE_LSB]);
    endproperty
    a_three_core: assert property (p_three_core) // RULE_08
        else $error("three-core ratio wrong");

    property p_four_core;
        s_ratio_open_write |=> four_core_ratio
            == $past(wdata[FOUR_CORE_LSB+RATIO_W-1:FOUR_CORE_LSB]);
    endproperty
    a_four_core: assert property (p_four_core) // RULE_09
        else $error("four-core ratio wrong");

    property p_reserved_zero;
        rd |=> rdata[DATA_W-1:LIVE_W] == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE_10
        else $error("reserved bits read nonzero");

    property p_ratio_locked;
        s_ratio_locked_write |=> $stable(one_core_ratio)
            && $stable(two_core_ratio) && $stable(three_core_ratio)
            && $stable(four_core_ratio);
    endproperty
    a_ratio_locked: assert property (p_ratio_locked) // RULE_11
        else $error("locked ratio register changed");

    property p_ratio_readback;
        s_ratio_read ##1 s_ratio_read |=> rdata == $past(rdata, 1);
    endproperty
    a_ratio_readback: assert property (p_ratio_readback) // RULE_05
        else $error("ratio readback unstable without write");

    property p_rdata_one_cycle;
        !rd |=> rdata == RDATA_RESET;
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle)
        else $error("read data held beyond one cycle");

    // Holes in the map read as zero, never as stale data
    property p_unmapped_read;
        rd && !addr_hits(addr, PWR_ADDR) && !addr_hits(addr, RATIO_ADDR)
            |=> rdata == RDATA_RESET;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned data");

    // Readback packs the four ratios as stored
    property p_ratio_value;
        s_ratio_read |=>
            rdata[LIVE_W-1:0] == {$past(four_core_ratio),
                                  $past(three_core_ratio),
                                  $past(two_core_ratio),
                                  $past(one_core_ratio)};
    endproperty
    a_ratio_value: assert property (p_ratio_value) // RULE_06
        else $error("ratio register readback wrong");

    // A read has no side effect on the stored word
    property p_pwr_repeat_read;
        s_pwr_read ##1 s_pwr_read |=> rdata == $past(rdata, 1);
    endproperty
    a_pwr_repeat_read: assert property (p_pwr_repeat_read) // RULE_01
        else $error("power readback unstable without write");

    // Only a power-register write may move its fields
    property p_pwr_hold;
        !rst && !(wr && addr_hits(addr, PWR_ADDR)) |=>
            $stable(thermal_design_power_ceiling)
            && $stable(power_override_en)
            && $stable(design_current_ceiling)
            && $stable(current_override_en);
    endproperty
    a_pwr_hold: assert property (p_pwr_hold) // RULE_02
        else $error("power register moved without a write");

    // A locked write counts as no write at all
    property p_ratio_hold;
        !rst && !(wr && addr_hits(addr, RATIO_ADDR)
                  && platform_capability_word[WRITABLE_BIT]) |=>
            $stable(one_core_ratio) && $stable(two_core_ratio)
            && $stable(three_core_ratio) && $stable(four_core_ratio);
    endproperty
    a_ratio_hold: assert property (p_ratio_hold) // RULE_11
        else $error("ratio register moved without an open write");

    // The refused value must not leak out through the read path either
    property p_locked_then_read;
        s_ratio_locked_write ##1 s_ratio_read |=>
            rdata[LIVE_W-1:0] == {$past(four_core_ratio, 2),
                                  $past(three_core_ratio, 2),
                                  $past(two_core_ratio, 2),
                                  $past(one_core_ratio, 2)};
    endproperty
    a_locked_then_read: assert property (p_locked_then_read) // RULE_11
        else $error("locked write visible on readback");

    // Read straight after write sees the new word, upper half dropped
    property p_pwr_write_read;
        s_pwr_write ##1 s_pwr_read |=>
            rdata == {32'h0000_0000, $past(wdata[LIVE_W-1:0], 2)};
    endproperty
    a_pwr_write_read: assert property (p_pwr_write_read) // RULE_10
        else $error("power write not seen on next read");

    property p_open_write_read;
        s_ratio_open_write ##1 s_ratio_read |=>
            rdata == {32'h0000_0000, $past(wdata[LIVE_W-1:0], 2)};
    endproperty
    a_open_write_read: assert property (p_open_write_read) // RULE_05
        else $error("open ratio write not seen on next read");

    // Reset wins over a write in the same cycle and clears everything
    property p_reset_clear;
        disable iff (1'h0)
        rst |=> rdata == RDATA_RESET
            && {current_override_en, design_current_ceiling,
                power_override_en, thermal_design_power_ceiling} == PWR_RESET
            && {four_core_ratio, three_core_ratio,
                two_core_ratio, one_core_ratio} == RATIO_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("state survived reset");

endmodule
`default_nettype wire

// >>> logic/pwr_caps_reg.sv
`timescale 1ns/10ps
`default_nettype none
module pwr_caps_reg (
    input wire logic clk,
    input wire logic rst,
    caps_if.pwr bus
);
    import caps_pkg::*;

    typedef struct packed {
        pwr_caps_t caps;
    } pwr_state_t;

    pwr_state_t state_reg;
    pwr_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (bus.pwr_we) begin
            state_next.caps = pwr_caps_t'(bus.wdata); // RULE_01
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{caps: PWR_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.pwr_q = state_reg.caps;
endmodule
`default_nettype wire

// >>> logic/ratio_caps_reg.sv
`timescale 1ns/10ps
`default_nettype none
module ratio_caps_reg (
    input wire logic clk,
    input wire logic rst,
    caps_if.ratio bus
);
    import caps_pkg::*;

    typedef struct packed {
        ratio_caps_t caps;
    } ratio_state_t;

    ratio_state_t state_reg;
    ratio_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // Locked writes are dropped silently, no error is flagged
        if (bus.ratio_we && bus.ratio_writable) begin // RULE_05 RULE_11
            state_next.caps = ratio_caps_t'(bus.wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{caps: RATIO_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.ratio_q = state_reg.caps;
endmodule
`default_nettype wire

// >>> pkg/caps_if.sv
`timescale 1ns/10ps
`default_nettype none
interface caps_if;
    import caps_pkg::*;

    logic pwr_we;
    logic ratio_we;
    logic ratio_writable;
    logic [LIVE_W-1:0] wdata;
    pwr_caps_t pwr_q;
    ratio_caps_t ratio_q;

    modport ctrl(
        output pwr_we,
        output ratio_we,
        output ratio_writable,
        output wdata,
        input pwr_q,
        input ratio_q
    );
    modport pwr(
        input pwr_we,
        input wdata,
        output pwr_q
    );
    modport ratio(
        input ratio_we,
        input ratio_writable,
        input wdata,
        output ratio_q
    );
endinterface
`default_nettype wire

// >>> pkg/caps_pkg.sv
`default_nettype none
package caps_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 64;
    localparam int LIVE_W = 32;
    localparam int RATIO_W = 8;
    localparam int LIMIT_W = 15;

    // Register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] PWR_INDEX = 12'h1ac;
    localparam logic [ADDR_W-1:0] RATIO_INDEX = 12'h1ad;
    localparam logic [ADDR_W-1:0] PWR_ADDR = {PWR_INDEX[9:0], 2'b00};
    localparam logic [ADDR_W-1:0] RATIO_ADDR = {RATIO_INDEX[9:0], 2'b00};

    // Field positions of the power/current register
    localparam int PWR_LIMIT_LSB = 0;
    localparam int PWR_LIMIT_MSB = 14;
    localparam int PWR_OVR_BIT = 15;
    localparam int CUR_LIMIT_LSB = 16;
    localparam int CUR_LIMIT_MSB = 30;
    localparam int CUR_OVR_BIT = 31;

    // Field positions of the boost-ratio register
    localparam int ONE_CORE_LSB = 0;
    localparam int TWO_CORE_LSB = 8;
    localparam int THREE_CORE_LSB = 16;
    localparam int FOUR_CORE_LSB = 24;

    // Capability bit that unlocks boost-ratio writes
    localparam int WRITABLE_BIT = 28;

    typedef struct packed {
        logic cur_ovr;
        logic [LIMIT_W-1:0] cur_limit;
        logic pwr_ovr;
        logic [LIMIT_W-1:0] pwr_limit;
    } pwr_caps_t;

    typedef struct packed {
        logic [RATIO_W-1:0] four;
        logic [RATIO_W-1:0] three;
        logic [RATIO_W-1:0] two;
        logic [RATIO_W-1:0] one;
    } ratio_caps_t;

    localparam pwr_caps_t PWR_RESET = 32'h0000_0000;
    localparam ratio_caps_t RATIO_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 64'h0;

    function automatic logic addr_hits(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] target);
        addr_hits = (a == target);
    endfunction

    // Upper word is reserved and always reads as zero
    function automatic logic [DATA_W-1:0] widen(input logic [LIVE_W-1:0] w);
        widen = {32'h0000_0000, w};
    endfunction

endpackage
`default_nettype wire

// >>> testbench/tb_power_current_ratio_limits.sv
`timescale 1ns/10ps
`default_nettype none
module tb_power_current_ratio_limits;
    import caps_pkg::*;

    logic clk;
    logic rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] platform_capability_word;
    logic [DATA_W-1:0] rdata;
    logic [LIMIT_W-1:0] thermal_design_power_ceiling;
    logic power_override_en;
    logic [LIMIT_W-1:0] design_current_ceiling;
    logic current_override_en;
    logic [RATIO_W-1:0] one_core_ratio;
    logic [RATIO_W-1:0] two_core_ratio;
    logic [RATIO_W-1:0] three_core_ratio;
    logic [RATIO_W-1:0] four_core_ratio;

    int failures = 0;
    int comparisons = 0;
    logic [63:0] seed = 64'h32;
    logic [31:0] pwr_m = 32'h0;
    logic [31:0] ratio_m = 32'h0;
    logic [63:0] exp_q[$];
    bit rd_q = 1'b0;

    power_current_ratio_limits dut_u (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .platform_capability_word(platform_capability_word),
        .rdata(rdata),
        .thermal_design_power_ceiling(thermal_design_power_ceiling),
        .power_override_en(power_override_en),
        .design_current_ceiling(design_current_ceiling),
        .current_override_en(current_override_en),
        .one_core_ratio(one_core_ratio),
        .two_core_ratio(two_core_ratio),
        .three_core_ratio(three_core_ratio),
        .four_core_ratio(four_core_ratio)
    );

    function automatic logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction

    task automatic chk(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Every call leaves its strobe up; idle() drops both, so no signal
    // is assigned twice in one time step on back-to-back access
    task automatic bus(input bit w, input logic [11:0] a,
                       input logic [63:0] d, input logic cap);
        logic [63:0] p;
        p = rnd();
        p[WRITABLE_BIT] = cap;
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        platform_capability_word <= p;
        @(posedge clk);
        if (w) begin
            if (a === PWR_ADDR) pwr_m = d[31:0];
            else if (a === RATIO_ADDR && cap) ratio_m = d[31:0];
        end else if (a === PWR_ADDR) begin
            exp_q.push_back({32'h0, pwr_m});
        end else if (a === RATIO_ADDR) begin
            exp_q.push_back({32'h0, ratio_m});
        end else begin
            exp_q.push_back(64'h0);
        end
    endtask

    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) rd_q <= rd;

    // Read data is judged against the queue in the cycle after the strobe, and against zero in every other cycle
    always @(negedge clk) begin
        if (rst === 1'b0) begin
            if (rd_q && exp_q.size() == 0) chk("read queue", 64'h1, 64'h0);
            else if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
            else chk("idle rdata", 64'h0, rdata);
            chk("power", 64'(pwr_m[14:0]), 64'(thermal_design_power_ceiling));
            chk("power ovr", 64'(pwr_m[15]), 64'(power_override_en));
            chk("current", 64'(pwr_m[30:16]), 64'(design_current_ceiling));
            chk("current ovr", 64'(pwr_m[31]), 64'(current_override_en));
            chk("one", 64'(ratio_m[7:0]), 64'(one_core_ratio));
            chk("two", 64'(ratio_m[15:8]), 64'(two_core_ratio));
            chk("three", 64'(ratio_m[23:16]), 64'(three_core_ratio));
            chk("four", 64'(ratio_m[31:24]), 64'(four_core_ratio));
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        $display("CHECK FAILED watchdog expected done seen hang");
        tally_and_finish();
    end

    initial begin
        logic [63:0] r;
        logic [11:0] a;
        logic [11:0] holes[6];
        holes = '{12'h1ac, 12'h1ad, 12'h6af, 12'h6b1, 12'h6b8, 12'hfff};
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h0;
        wdata = 64'h0;
        platform_capability_word = 64'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, PWR_ADDR, 64'h0, 1'b1);
        bus(0, RATIO_ADDR, 64'h0, 1'b1);
        // Walking ones cover every field edge; upper half must drop
        for (int i = 0; i < 32; i++) begin
            bus(1, PWR_ADDR, (64'h1 << i) | (64'h1 << (32 + i)), 1'b0);
            bus(0, PWR_ADDR, 64'h0, 1'b0);
            bus(1, RATIO_ADDR, (64'h1 << i) | (64'h1 << (32 + i)), 1'b1);
            bus(0, RATIO_ADDR, 64'h0, 1'b0);
        end
        bus(1, RATIO_ADDR, 64'hffff_ffff_ffff_ffff, 1'b0);
        bus(0, RATIO_ADDR, 64'h0, 1'b1);
        bus(1, PWR_ADDR, 64'hffff_ffff_ffff_ffff, 1'b0);
        foreach (holes[k]) begin
            bus(1, holes[k], 64'h0, 1'b1);
            bus(0, holes[k], 64'h0, 1'b1);
        end
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            case (r[1:0])
                2'h0: a = PWR_ADDR;
                2'h1, 2'h2: a = RATIO_ADDR;
                default: a = r[13:2];
            endcase
            bus(r[2], a, rnd(), r[3]);
        end
        idle();
        // Mid-run reset must clear both registers
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        pwr_m = 32'h0;
        ratio_m = 32'h0;
        @(posedge clk);
        bus(0, PWR_ADDR, 64'h0, 1'b1);
        bus(0, RATIO_ADDR, 64'h0, 1'b1);
        idle();
        idle();
        tally_and_finish();
    end
endmodule
`default_nettype wire
